// [tw_regs.sv]
// two-wire master task, event and link registers behind an apb slave
// assumes a synchronous apb master on pclk and open-drain pins outside
// What this block does
// - writing one to the resume trigger continues a paused transfer
// - byte received flag sets once a byte lands in the receive register
// - byte sent flag sets once a transmit byte went out on the bus and was acknowledged
// - byte boundary flag rises before each byte sent or received
// - paused flag rises right after the read acknowledge when pausing
// - paused event only appears when a pause was requested before
// - boundary to pause link makes each boundary event request a pause
// - boundary to halt link makes each boundary event request a stop
`timescale 1ns/1ps
module tw_regs
  import tw_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe
);

  if (ADDR_W != 12) begin : g_chk
    $error("tw_regs: address width must be 12");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // which event flag sits at an address, IDX_NONE when none
  function automatic logic [2:0] flag_idx(input logic [ADDR_W-1:0] a);
    logic [2:0] r;
    r = IDX_NONE;
    unique case (a)
      OFF_STOPPED:  r = 3'h0;
      OFF_RXD:      r = 3'h1;
      OFF_TXD:      r = 3'h2;
      OFF_FAULT:    r = 3'h3;
      OFF_BOUNDARY: r = 3'h4;
      OFF_PAUSED:   r = 3'h5;
      default:      r = IDX_NONE;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [5:0]  flags_ff, nxt_flags;
  logic [5:0]  stat_ff, nxt_stat;
  logic [5:0]  mask_ff;
  logic [1:0]  links_ff;
  logic [7:0]  tx_ff;
  logic [6:0]  taddr_ff;
  tw_task_s    task_ff, nxt_task;
  logic        scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff;
  tw_ev_s      ev;
  logic [7:0]  rx_byte;
  logic        busy;
  logic        eng_scl_oe, eng_sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // one wait state: pready rises in the second access cycle
  wire         acc      = psel && penable;
  wire         fire     = acc && pready;
  wire         wr_fire  = fire && pwrite;
  wire [2:0]   widx     = flag_idx(paddr);
  wire         is_flag  = (widx != IDX_NONE);
  wire         mapped   = is_flag || paddr == OFF_RESUME || paddr == OFF_LINKS ||
                          paddr == OFF_CMD || paddr == OFF_TXBYTE ||
                          paddr == OFF_RXBYTE || paddr == OFF_TADDR ||
                          paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK ||
                          paddr == OFF_STATE;
  wire         wr_flag  = wr_fire && is_flag;
  wire         wr_links = wr_fire && paddr == OFF_LINKS;
  wire         wr_cmd   = wr_fire && paddr == OFF_CMD;
  wire         wr_rsm   = wr_fire && paddr == OFF_RESUME;
  wire         wr_stat  = wr_fire && paddr == OFF_IRQ_STAT;
  wire [5:0]   ev_vec   = ev;
  wire [5:0]   wsel     = is_flag ? (6'h01 << widx) : 6'h00;

  // read selection; the resume trigger and command word read as zero
  wire [31:0]  rd_val =
    is_flag                  ? {31'h0, flags_ff[widx]} :
    paddr == OFF_LINKS       ? {30'h0, links_ff} :
    paddr == OFF_TXBYTE      ? {24'h0, tx_ff} :
    paddr == OFF_RXBYTE      ? {24'h0, rx_byte} :
    paddr == OFF_TADDR       ? {25'h0, taddr_ff} :
    paddr == OFF_IRQ_STAT    ? {26'h0, stat_ff} :
    paddr == OFF_IRQ_MASK    ? {26'h0, mask_ff} :
    paddr == OFF_STATE       ? {31'h0, busy} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // task strobes, one cycle after the write that fires them

  // boundary events feed the pause and stop tasks through the links
  assign nxt_task.resume   = wr_rsm && pwdata[0];
  assign nxt_task.pause    = (wr_cmd && pwdata[CMD_PAUSE]) ||
                             (ev.boundary && links_ff[LNK_PAUSE]);
  assign nxt_task.stop     = (wr_cmd && pwdata[CMD_STOP]) ||
                             (ev.boundary && links_ff[LNK_HALT]);
  assign nxt_task.start_tx = wr_cmd && pwdata[CMD_TX];
  assign nxt_task.start_rx = wr_cmd && pwdata[CMD_RX];

  ////////////////////////////////////////////////////////////////////////////
  // event flags and interrupt status; a new event wins over a clear

  // a written zero clears a flag, a written one sets it
  assign nxt_flags = ev_vec | (wr_flag ? ((flags_ff & ~wsel) | ({6{pwdata[0]}} & wsel))
                                       : flags_ff);
  // interrupt status clears by writing ones
  assign nxt_stat  = ev_vec | (wr_stat ? (stat_ff & ~pwdata[5:0]) : stat_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= FLAGS_RST;
      stat_ff  <= FLAGS_RST;
      irq      <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      stat_ff  <= nxt_stat;
      irq      <= |(nxt_stat & mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-owned configuration

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      links_ff <= LINKS_RST;
      mask_ff  <= FLAGS_RST;
      tx_ff    <= BYTE_RST;
      taddr_ff <= TADDR_RST;
      task_ff  <= '0;
    end else begin
      if (wr_links) links_ff <= pwdata[1:0];
      if (wr_fire && paddr == OFF_IRQ_MASK) mask_ff <= pwdata[5:0];
      if (wr_fire && paddr == OFF_TXBYTE) tx_ff <= pwdata[7:0];
      if (wr_fire && paddr == OFF_TADDR) taddr_ff <= pwdata[6:0];
      task_ff <= nxt_task;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      prdata  <= (acc && !pready && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end
  assign scl_oe = eng_scl_oe;
  assign sda_oe = eng_sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  tw_engine #(
    .QTR     (QTR)
  ) u_engine (
    .pclk    (pclk),
    .presetn (presetn),
    .task_in (task_ff),
    .tx_byte (tx_ff),
    .taddr   (taddr_ff),
    .scl_in  (scl_s_ff),
    .sda_in  (sda_s_ff),
    .scl_oe  (eng_scl_oe),
    .sda_oe  (eng_sda_oe),
    .ev      (ev),
    .rx_byte (rx_byte),
    .busy    (busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  resume_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == OFF_RESUME && pwdata[0] |=> task_ff.resume)
    else $error("resume write did not trigger the resume task");

  rxd_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.rxd |=> flags_ff[1] && stat_ff[1])
    else $error("byte received flag not set");

  txd_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.txd |=> flags_ff[2])
    else $error("byte sent flag not set");

  boundary_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.boundary |=> flags_ff[4])
    else $error("byte boundary flag not set");

  paused_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.paused |=> flags_ff[5] ##1 flags_ff[5] || $past(wr_flag))
    else $error("paused flag not set after pausing");

  link_pause_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.boundary && links_ff[LNK_PAUSE] |=> task_ff.pause)
    else $error("pause link did not raise the pause task");

  link_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.boundary && links_ff[LNK_HALT] |=> task_ff.stop)
    else $error("halt link did not raise the stop task");

  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    flags_ff[0] && !(wr_flag && widx == 3'h0) |=> flags_ff[0])
    else $error("stopped flag dropped without a write");

  fault_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.fault |=> flags_ff[3] && stat_ff[3])
    else $error("fault flag not set on bus error");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(stat_ff & mask_ff) && !wr_fire |=> irq)
    else $error("interrupt not raised for an unmasked status bit");

  irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(stat_ff & mask_ff)) && !(|ev_vec) && !wr_fire |=> !irq)
    else $error("interrupt raised with no unmasked status bit");

  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  slverr_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr raised outside a completion");

  wo_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && (paddr == OFF_RESUME || paddr == OFF_CMD) |-> prdata == 32'h0)
    else $error("write-only register read back non-zero");

  links_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_links |=> links_ff == $past(pwdata[1:0]))
    else $error("link register write lost");

  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_flag && !pwdata[0] && !ev_vec[widx] |=> !flags_ff[$past(widx)])
    else $error("event flag not cleared by a zero write");

  stopped_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.stopped |=> flags_ff[0] && stat_ff[0])
    else $error("stopped flag not set");

  stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_stat && pwdata[0] && !ev.stopped |=> !stat_ff[0])
    else $error("stopped status not cleared by a one write");

  lines_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !busy |-> !scl_oe && !sda_oe)
    else $error("two-wire lines pulled while idle");

endmodule // tw_regs

// [tw_pkg.sv]
// shared constants and carrier types for the two-wire task and event block
// assumes a 250 MHz apb clock and a 100 kHz two-wire bit rate
package tw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus and timing
  localparam int          ADDR_W   = 12;
  localparam int          CLK_PS   = 4000;    // pclk period in ps
  localparam int          BIT_NS   = 10000;   // two-wire bit period in ns
  // a bit is four quarter phases; longest quarter rounds down
  localparam int          QTR_CYC  = (BIT_NS * 1000 / 4) / CLK_PS;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [11:0] OFF_RESUME   = 12'h020;
  localparam logic [11:0] OFF_STOPPED  = 12'h104;
  localparam logic [11:0] OFF_RXD      = 12'h108;
  localparam logic [11:0] OFF_TXD      = 12'h11c;
  localparam logic [11:0] OFF_FAULT    = 12'h124;
  localparam logic [11:0] OFF_BOUNDARY = 12'h138;
  localparam logic [11:0] OFF_PAUSED   = 12'h148;
  localparam logic [11:0] OFF_LINKS    = 12'h200;
  localparam logic [11:0] OFF_CMD      = 12'h600;
  localparam logic [11:0] OFF_TXBYTE   = 12'h604;
  localparam logic [11:0] OFF_RXBYTE   = 12'h608;
  localparam logic [11:0] OFF_TADDR    = 12'h60c;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h610;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h614;
  localparam logic [11:0] OFF_STATE    = 12'h618;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          LNK_PAUSE   = 0;    // boundary_to_pause_link
  localparam int          LNK_HALT    = 1;    // boundary_to_halt_link
  localparam int          CMD_RX      = 0;
  localparam int          CMD_TX      = 1;
  localparam int          CMD_STOP    = 2;
  localparam int          CMD_PAUSE   = 3;
  localparam int          EV_N        = 6;
  localparam logic [2:0]  IDX_NONE    = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [5:0]  FLAGS_RST   = 6'h00;
  localparam logic [1:0]  LINKS_RST   = 2'h0;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [6:0]  TADDR_RST   = 7'h00;

  // event strobes; bit 0 is stopped, order matches the flag offsets
  typedef struct packed {
    logic paused;
    logic boundary;
    logic fault;
    logic txd;
    logic rxd;
    logic stopped;
  } tw_ev_s;

  // task strobes into the engine
  typedef struct packed {
    logic resume;
    logic pause;
    logic stop;
    logic start_tx;
    logic start_rx;
  } tw_task_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_BIT   = 3'b010,
    ST_ACK   = 3'b011,
    ST_PAUSE = 3'b100,
    ST_STOP  = 3'b101
  } tw_state_e;

endpackage

// [tw_engine.sv]
// two-wire byte engine: start, address, data bytes, ack, pause and stop
// assumes scl_in and sda_in are already synchronised to pclk
`timescale 1ns/1ps
module tw_engine
  import tw_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire tw_task_s   task_in,
  input  wire logic [7:0] tx_byte,
  input  wire logic [6:0] taddr,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_oe,
  output logic            sda_oe,
  output tw_ev_s          ev,
  output logic [7:0]      rx_byte,
  output logic            busy
);

  if (QTR < 2 || QTR > 65535) begin : g_chk
    $error("tw_engine: QTR out of range");
  end

  tw_state_e   st_ff, nxt_st;
  logic [1:0]  q_ff, nxt_q;
  logic [2:0]  bit_ff, nxt_bit;
  logic [7:0]  sh_ff, nxt_sh, nxt_rx;
  logic [15:0] cnt_ff;
  logic        rd_ff, nxt_rd, addr_ph_ff, nxt_addr_ph, samp_ff, nxt_samp;
  logic        pause_req_ff, nxt_pause_req, stop_req_ff, nxt_stop_req;
  logic        nxt_scl, nxt_sda;
  tw_ev_s      nxt_ev;

  // quarter tick; a released scl held low by the slave stretches the bit
  wire timed   = (st_ff != ST_IDLE) && (st_ff != ST_PAUSE);
  wire tick    = timed && (cnt_ff == 16'(QTR - 1));
  wire adv     = tick && !(q_ff == 2'h2 && !scl_in);
  wire sending = addr_ph_ff || !rd_ff;
  wire nack    = sending && samp_ff;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff; nxt_q = q_ff; nxt_bit = bit_ff; nxt_sh = sh_ff;
    nxt_rd = rd_ff; nxt_addr_ph = addr_ph_ff; nxt_samp = samp_ff;
    nxt_scl = scl_oe; nxt_sda = sda_oe; nxt_rx = rx_byte; nxt_ev = '0;
    nxt_pause_req = pause_req_ff || (task_in.pause && st_ff != ST_IDLE);
    nxt_stop_req  = stop_req_ff || (task_in.stop && st_ff != ST_IDLE);
    if (adv) nxt_q = q_ff + 2'h1;
    unique case (st_ff)
      ST_IDLE: begin
        if (task_in.stop) nxt_ev.stopped = 1'b1;
        if (task_in.start_rx || task_in.start_tx) begin
          nxt_st = ST_START; nxt_q = 2'h0; nxt_rd = task_in.start_rx;
          nxt_pause_req = 1'b0; nxt_stop_req = 1'b0;
        end
      end
      ST_START: if (adv) begin
        if (q_ff == 2'h0) nxt_sda = 1'b1;            // start condition
        else begin
          nxt_scl = 1'b1; nxt_st = ST_BIT; nxt_q = 2'h0; nxt_bit = 3'h7;
          nxt_sh = {taddr, rd_ff}; nxt_addr_ph = 1'b1;
          nxt_ev.boundary = 1'b1;
        end
      end
      ST_BIT: if (adv) begin
        unique case (q_ff)
          2'h0: nxt_sda = sending && !sh_ff[7];
          2'h1: nxt_scl = 1'b0;
          2'h2: nxt_sh = {sh_ff[6:0], sda_in};
          2'h3: begin
            nxt_scl = 1'b1;
            if (bit_ff == 3'h0) nxt_st = ST_ACK;
            else nxt_bit = bit_ff - 3'h1;
          end
        endcase
      end
      ST_ACK: if (adv) begin
        unique case (q_ff)
          2'h0: nxt_sda = !sending && !stop_req_ff;  // nack the last read byte
          2'h1: nxt_scl = 1'b0;
          2'h2: nxt_samp = sda_in;
          2'h3: begin
            nxt_scl = 1'b1; nxt_sda = 1'b0; nxt_q = 2'h0;
            nxt_ev.fault = nack;
            nxt_ev.txd = !nack && !addr_ph_ff && !rd_ff;
            nxt_ev.rxd = !addr_ph_ff && rd_ff;
            if (!addr_ph_ff && rd_ff) nxt_rx = sh_ff;
            if (nack || stop_req_ff) nxt_st = ST_STOP;
            else if (pause_req_ff) begin
              nxt_st = ST_PAUSE; nxt_pause_req = 1'b0;
              nxt_ev.paused = rd_ff;
            end else begin
              nxt_st = ST_BIT; nxt_bit = 3'h7; nxt_addr_ph = 1'b0;
              nxt_sh = rd_ff ? BYTE_RST : tx_byte;
              nxt_ev.boundary = 1'b1;
            end
          end
        endcase
      end
      ST_PAUSE: begin
        nxt_q = 2'h0;
        if (stop_req_ff) nxt_st = ST_STOP;
        else if (task_in.resume) begin
          nxt_st = ST_BIT; nxt_bit = 3'h7; nxt_addr_ph = 1'b0;
          nxt_sh = rd_ff ? BYTE_RST : tx_byte;
          nxt_ev.boundary = 1'b1;
        end
      end
      ST_STOP: if (adv) begin
        unique case (q_ff)
          2'h0: nxt_sda = 1'b1;
          2'h1: nxt_scl = 1'b0;
          2'h2: nxt_sda = 1'b0;                      // stop condition
          2'h3: begin
            nxt_st = ST_IDLE; nxt_ev.stopped = 1'b1; nxt_stop_req = 1'b0;
          end
        endcase
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE; q_ff <= 2'h0; bit_ff <= 3'h0; sh_ff <= BYTE_RST;
      rd_ff <= 1'b0; addr_ph_ff <= 1'b0; samp_ff <= 1'b0; cnt_ff <= 16'h0000;
      pause_req_ff <= 1'b0; stop_req_ff <= 1'b0; scl_oe <= 1'b0;
      sda_oe <= 1'b0; ev <= '0; rx_byte <= BYTE_RST; busy <= 1'b0;
    end else begin
      st_ff <= nxt_st; q_ff <= nxt_q; bit_ff <= nxt_bit; sh_ff <= nxt_sh;
      rd_ff <= nxt_rd; addr_ph_ff <= nxt_addr_ph; samp_ff <= nxt_samp;
      cnt_ff <= (!timed || tick || nxt_st != st_ff) ? 16'h0000 : cnt_ff + 16'h1;
      pause_req_ff <= nxt_pause_req; stop_req_ff <= nxt_stop_req;
      scl_oe <= nxt_scl; sda_oe <= nxt_sda; ev <= nxt_ev; rx_byte <= nxt_rx;
      busy <= (nxt_st != ST_IDLE);
    end
  end

  // a paused event follows only an earlier pause request
  pause_needs_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev.paused |-> $past(pause_req_ff) && $past(st_ff) == ST_ACK)
    else $error("paused event without a pending pause request");

endmodule // tw_engine

// [tw_slave_model.sv]
// behavioural two-wire slave that answers the master under test
// assumes pulled-up wire levels and a pclk much faster than the bit rate
`timescale 1ns/1ps
module tw_slave_model
  import tw_pkg::*;
#(
  parameter logic [6:0] SLV_ADDR = 7'h2a,
  parameter logic [7:0] RD_BYTE  = 8'h3c
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  output logic [7:0]      last_rx
);
  logic       scl_q, sda_q, adr_ph, rd_ff, snd_ff, ack_ok;
  logic [3:0] cnt;
  logic [7:0] sh;
  // line conditions seen on pclk
  wire start_seen = scl & scl_q & sda_q & ~sda;
  wire stop_seen  = scl & scl_q & ~sda_q & sda;
  wire rise       = scl & ~scl_q;
  wire fall       = ~scl & scl_q;
  wire hit        = sh[7:1] == SLV_ADDR;
  wire rd_go      = adr_ph ? hit & sh[0] : rd_ff & ack_ok;
  //////////////////////////////////////////////////////////////////////////////
  // bit counter, shifter and sda drive; data changes only while scl is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_q, sda_q} <= 2'h3;
      {adr_ph, rd_ff, snd_ff, ack_ok, sda_pull} <= 5'h00;
      cnt <= 4'h0;
      sh <= 8'h00;
      last_rx <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_seen) begin
        {cnt, adr_ph, snd_ff, sda_pull} <= 7'h04;
      end else if (stop_seen) begin
        {snd_ff, sda_pull} <= 2'h0;
      end else if (rise) begin
        if (cnt < 4'h8) sh <= {sh[6:0], sda};
        else ack_ok <= ~sda;
        cnt <= cnt + 4'h1;
      end else if (fall && cnt == 4'h8) begin
        snd_ff <= 1'b0;
        sda_pull <= adr_ph ? hit : ~rd_ff;  // no ack for a foreign address
        if (!adr_ph && !rd_ff) last_rx <= sh;
      end else if (fall && cnt == 4'h9) begin
        cnt <= 4'h0;
        adr_ph <= 1'b0;
        if (adr_ph) rd_ff <= sh[0];
        snd_ff <= rd_go;
        sda_pull <= rd_go & ~RD_BYTE[7];
      end else if (fall && snd_ff) begin
        sda_pull <= ~RD_BYTE[3'd7 - cnt[2:0]];
      end
    end
  end
endmodule // tw_slave_model

// [tw_regs_tb_top.sv]
// testbench of the two-wire task and event registers over apb
// assumes the slave model on the wires and a short quarter-bit count
`timescale 1ns/1ps
module tw_regs_tb_top
  import tw_pkg::*;
;
  localparam logic [6:0] SLV   = 7'h2a;
  localparam logic [7:0] RDB   = 8'h3c;
  localparam int         LIMIT = 40000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er_q;
  logic        scl_out, scl_oe, sda_out, sda_oe, sda_pull;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [7:0]  slv_rx;
  int          errors, n_checks, cyc;
  logic [11:0] offs [8] = '{OFF_RESUME, OFF_STOPPED, OFF_RXD, OFF_TXD, OFF_FAULT,
                            OFF_BOUNDARY, OFF_PAUSED, OFF_LINKS};
  // open-drain wires with pull-ups
  wire scl_w = ~scl_oe;
  wire sda_w = ~(sda_oe | sda_pull);
  //////////////////////////////////////////////////////////////////////////////
  tw_regs #(.QTR(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe));
  tw_slave_model #(.SLV_ADDR(SLV), .RD_BYTE(RDB)) slave (.pclk(pclk),
    .presetn(presetn), .scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .last_rx(slv_rx));
  //////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      end_of_test();
    end
  end
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  // polls a flag under a bounded count
  task automatic wait_flag(input logic [11:0] a);
    int i;
    i = 0;
    apb(1'b0, a, 32'h0);
    while (rd_q[0] !== 1'b1 && i < 400) begin
      apb(1'b0, a, 32'h0);
      i++;
    end
    chk(rd_q, 32'h1);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped place, sticky flags and write-only resume
    foreach (offs[i]) rchk(offs[i], 32'h0);
    apb(1'b0, 12'h7fc, 32'h0);
    chk({31'h0, er_q}, 32'h1);
    apb(1'b1, OFF_BOUNDARY, 32'h1);
    rchk(OFF_BOUNDARY, 32'h1);
    apb(1'b1, OFF_BOUNDARY, 32'h0);
    rchk(OFF_BOUNDARY, 32'h0);
    apb(1'b1, OFF_LINKS, 32'h3);
    rchk(OFF_LINKS, 32'h3);
    apb(1'b1, OFF_LINKS, 32'h0);
    apb(1'b1, OFF_RESUME, 32'h1);
    rchk(OFF_RESUME, 32'h0);
    // write transfer, stop only after the byte sent event
    apb(1'b1, OFF_TADDR, {25'h0, SLV});
    apb(1'b1, OFF_TXBYTE, 32'ha5);
    rchk(OFF_TXBYTE, 32'ha5);
    apb(1'b1, OFF_CMD, 32'h2);
    wait_flag(OFF_TXD);
    apb(1'b1, OFF_CMD, 32'h4);
    wait_flag(OFF_STOPPED);
    chk({24'h0, slv_rx}, 32'ha5);
    rchk(OFF_BOUNDARY, 32'h1);
    rchk(OFF_PAUSED, 32'h0);
    rchk(OFF_FAULT, 32'h0);
    rchk(OFF_RXD, 32'h0);
    // read paused by the boundary link, resumed, then halted by the other link
    foreach (offs[i]) if (i > 0 && i < 7) apb(1'b1, offs[i], 32'h0);
    apb(1'b1, OFF_LINKS, 32'h1);
    apb(1'b1, OFF_CMD, 32'h1);
    wait_flag(OFF_PAUSED);
    rchk(OFF_RXD, 32'h0);
    apb(1'b1, OFF_PAUSED, 32'h0);
    apb(1'b1, OFF_LINKS, 32'h2);
    apb(1'b1, OFF_RESUME, 32'h1);
    wait_flag(OFF_STOPPED);
    rchk(OFF_RXD, 32'h1);
    rchk(OFF_RXBYTE, {24'h0, RDB});
    rchk(OFF_PAUSED, 32'h0);
    // write paused by command before its data byte, then stopped
    apb(1'b1, OFF_LINKS, 32'h0);
    apb(1'b1, OFF_STOPPED, 32'h0);
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b1, OFF_CMD, 32'h8);
    repeat (200) @(posedge pclk);
    rchk(OFF_STATE, 32'h1);
    apb(1'b1, OFF_CMD, 32'h4);
    wait_flag(OFF_STOPPED);
    rchk(OFF_TXD, 32'h0);
    rchk(OFF_PAUSED, 32'h0);
    rchk(OFF_STATE, 32'h0);
    // foreign address gives a fault, then irq masked, unmasked and cleared
    apb(1'b1, OFF_IRQ_STAT, 32'h3f);
    apb(1'b1, OFF_STOPPED, 32'h0);
    apb(1'b1, OFF_TADDR, {25'h0, SLV ^ 7'h01});
    apb(1'b1, OFF_CMD, 32'h2);
    wait_flag(OFF_STOPPED);
    rchk(OFF_FAULT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h3f);
    rchk(OFF_IRQ_MASK, 32'h3f);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_IRQ_STAT, 32'h3f);
    rchk(OFF_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({28'h0, scl_out, sda_out, scl_oe, sda_oe}, 32'h0);
    end_of_test();
  end
endmodule // tw_regs_tb_top
